// ---- verilog/nco_pkg.sv ----
// Constants for the nibble core OR, rotate and table-fetch decoder.
// Assumes 16-bit instruction words with short opcodes left-aligned.
package nco_pkg;
   // ----------------------------------------------------------------
   // Widths and instruction fields
   // ----------------------------------------------------------------
   localparam int NIB_W   = 4;
   localparam int INSTR_W = 16;
   localparam int ADDR_W  = 7;
   localparam int RAM_D   = 128;
   localparam int TAB_W   = 8;
   localparam int OP9_HI  = 15;
   localparam int OP9_LO  = 7;
   localparam int OP8_LO  = 8;
   localparam int IMM_HI  = 7;
   localparam int IMM_LO  = 4;
   localparam int WR_HI   = 3;
   localparam int WR_LO   = 0;
   localparam int MSB     = 3;
   // Table page scale of sixteen words per high pointer step
   localparam logic [TAB_W-1:0] TAB_SCALE = 8'h10;

   // ----------------------------------------------------------------
   // Opcodes (nine-bit at [15:7], eight-bit at [15:8])
   // ----------------------------------------------------------------
   localparam logic [8:0] OP_TABLE_FETCH = 9'h132;
   localparam logic [8:0] OP_TAB_LOW     = 9'h130;
   localparam logic [8:0] OP_TAB_HIGH    = 9'h131;
   localparam logic [8:0] OP_OR_MEM      = 9'h034;
   localparam logic [8:0] OP_OR_MEM_WB   = 9'h076;
   localparam logic [8:0] OP_ROT_LEFT    = 9'h099;
   localparam logic [7:0] OP_OR_IMM      = 8'h1e;
   localparam logic [7:0] OP_OR_IMM_WB   = 8'h1f;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [NIB_W-1:0] NIB_RST  = 4'h0;
   localparam logic [TAB_W-1:0] TADR_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADR_RST = 7'h00;
endpackage : nco_pkg

// ---- verilog/nco_core.sv ----
// Execution logic for OR, rotate-left and table-fetch instructions.
// Assumes the fetch unit and table ROM run on clk_sys_i; the table ROM
// returns its word combinationally in the same cycle as the address.
`timescale 1ns/100ps

// Contract
// - Table fetch is opcode 100110010 plus a 7-bit address, two cycles.
// - Table address is high pointer times 16 plus low; word goes to RAM.
// - OR of RAM nibble and accumulator goes to accumulator only, one cycle.
// - Working register OR immediate goes to accumulator only, one cycle.
// - OR of RAM nibble and accumulator goes to both RAM and accumulator.
// - Working register OR immediate goes to both register and accumulator.
// - Rotate left through carry writes RAM and accumulator, sets carry.
// - Two move instructions load the low and high table pointers.
module nco_core (
   input  wire logic                        clk_sys_i,
   input  wire logic                        rstn_i,
   input  wire logic [nco_pkg::INSTR_W-1:0] instr_i,
   input  wire logic                        instr_valid_i,
   input  wire logic [nco_pkg::NIB_W-1:0]   table_data_i,
   input  wire logic                        load_en_i,
   input  wire logic [nco_pkg::ADDR_W-1:0]  load_addr_i,
   input  wire logic [nco_pkg::NIB_W-1:0]   load_data_i,
   input  wire logic [nco_pkg::ADDR_W-1:0]  peek_addr_i,
   output logic                             instr_ready_o,
   output logic      [nco_pkg::TAB_W-1:0]   table_addr_o,
   output logic      [nco_pkg::NIB_W-1:0]   accumulator_o,
   output logic                             zero_flag_o,
   output logic                             carry_flag_o,
   output logic      [nco_pkg::NIB_W-1:0]   table_pointer_low_o,
   output logic      [nco_pkg::NIB_W-1:0]   table_pointer_high_o,
   output logic      [nco_pkg::NIB_W-1:0]   peek_data_o
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [nco_pkg::TAB_W-1:0] tab_addr(
      input logic [nco_pkg::NIB_W-1:0] hi,
      input logic [nco_pkg::NIB_W-1:0] lo);
      tab_addr = nco_pkg::TAB_W'(hi) * nco_pkg::TAB_SCALE
               + nco_pkg::TAB_W'(lo);
   endfunction : tab_addr

   function automatic logic is_zero(input logic [nco_pkg::NIB_W-1:0] v);
      is_zero = (v == nco_pkg::NIB_RST);
   endfunction : is_zero

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [nco_pkg::NIB_W-1:0]  ram_q [nco_pkg::RAM_D];
   logic [nco_pkg::NIB_W-1:0]  ram_d [nco_pkg::RAM_D];
   logic [nco_pkg::NIB_W-1:0]  acc_q, acc_d;
   logic                       zf_q, zf_d, cf_q, cf_d;
   logic [nco_pkg::NIB_W-1:0]  tlo_q, tlo_d, thi_q, thi_d;
   logic [nco_pkg::TAB_W-1:0]  tadr_q, tadr_d;
   logic [nco_pkg::ADDR_W-1:0] pend_q, pend_d;
   logic                       busy_q, busy_d;
   logic                       ready_q;
   logic [nco_pkg::NIB_W-1:0]  peek_q;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic                       take;
   logic [8:0]                 op9;
   logic [7:0]                 op8;
   logic [nco_pkg::ADDR_W-1:0] raddr;
   logic [nco_pkg::NIB_W-1:0]  imm, widx, rnib, wnib, res;
   logic is_fetch, is_or_mem, is_or_mem_wb, is_rot, is_tlo, is_thi;
   logic is_or_imm, is_or_imm_wb;

   // A word is taken only while ready shows high, so nothing slips in
   // during reset or in the second cycle of a table fetch
   assign take  = instr_valid_i && ready_q;
   assign op9   = instr_i[nco_pkg::OP9_HI:nco_pkg::OP9_LO];
   assign op8   = instr_i[nco_pkg::OP9_HI:nco_pkg::OP8_LO];
   assign raddr = instr_i[nco_pkg::ADDR_W-1:0];
   assign imm   = instr_i[nco_pkg::IMM_HI:nco_pkg::IMM_LO];
   assign widx  = instr_i[nco_pkg::WR_HI:nco_pkg::WR_LO];
   assign rnib  = ram_q[raddr];
   // Working registers are the bottom sixteen RAM nibbles
   assign wnib  = ram_q[nco_pkg::ADDR_W'(widx)];
   assign is_fetch     = take && op9 == nco_pkg::OP_TABLE_FETCH;
   assign is_tlo       = take && op9 == nco_pkg::OP_TAB_LOW;
   assign is_thi       = take && op9 == nco_pkg::OP_TAB_HIGH;
   assign is_or_mem    = take && op9 == nco_pkg::OP_OR_MEM;
   assign is_or_mem_wb = take && op9 == nco_pkg::OP_OR_MEM_WB;
   assign is_rot       = take && op9 == nco_pkg::OP_ROT_LEFT;
   assign is_or_imm    = take && op8 == nco_pkg::OP_OR_IMM;
   assign is_or_imm_wb = take && op8 == nco_pkg::OP_OR_IMM_WB;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Preload port first so an instruction write to the same nibble wins
   always_comb begin
      ram_d  = ram_q;
      acc_d  = acc_q;
      zf_d   = zf_q;
      cf_d   = cf_q;
      tlo_d  = tlo_q;
      thi_d  = thi_q;
      tadr_d = tadr_q;
      pend_d = pend_q;
      busy_d = 1'b0;
      res    = nco_pkg::NIB_RST;
      if (load_en_i) begin
         ram_d[load_addr_i] = load_data_i;
      end
      if (busy_q) begin
         ram_d[pend_q] = table_data_i;
      end else if (is_fetch) begin
         tadr_d = tab_addr(thi_q, tlo_q);
         pend_d = raddr;
         busy_d = 1'b1;
      end else if (is_tlo) begin
         tlo_d = rnib;
      end else if (is_thi) begin
         thi_d = rnib;
      end else if (is_or_mem || is_or_mem_wb) begin
         res   = rnib | acc_q;
         acc_d = res;
         zf_d  = is_zero(res);
         if (is_or_mem_wb) begin
            ram_d[raddr] = res;
         end
      end else if (is_or_imm || is_or_imm_wb) begin
         res   = wnib | imm;
         acc_d = res;
         zf_d  = is_zero(res);
         if (is_or_imm_wb) begin
            ram_d[nco_pkg::ADDR_W'(widx)] = res;
         end
      end else if (is_rot) begin
         res          = {rnib[nco_pkg::MSB-1:0], cf_q};
         cf_d         = rnib[nco_pkg::MSB];
         acc_d        = res;
         ram_d[raddr] = res;
         zf_d         = is_zero(res);
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // RAM has no reset; software is expected to initialise it
   always_ff @(posedge clk_sys_i) begin
      ram_q <= ram_d;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_q   <= nco_pkg::NIB_RST;
         zf_q    <= 1'b0;
         cf_q    <= 1'b0;
         tlo_q   <= nco_pkg::NIB_RST;
         thi_q   <= nco_pkg::NIB_RST;
         tadr_q  <= nco_pkg::TADR_RST;
         pend_q  <= nco_pkg::ADR_RST;
         busy_q  <= 1'b0;
         ready_q <= 1'b0;
         peek_q  <= nco_pkg::NIB_RST;
      end else begin
         acc_q   <= acc_d;
         zf_q    <= zf_d;
         cf_q    <= cf_d;
         tlo_q   <= tlo_d;
         thi_q   <= thi_d;
         tadr_q  <= tadr_d;
         pend_q  <= pend_d;
         busy_q  <= busy_d;
         ready_q <= !busy_d;
         peek_q  <= ram_d[peek_addr_i];  // Shows writes of this edge
      end
   end

   // Outputs straight from flops
   assign instr_ready_o        = ready_q;
   assign table_addr_o         = tadr_q;
   assign accumulator_o        = acc_q;
   assign zero_flag_o          = zf_q;
   assign carry_flag_o         = cf_q;
   assign table_pointer_low_o  = tlo_q;
   assign table_pointer_high_o = thi_q;
   assign peek_data_o          = peek_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   fetch_two_cycle_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) is_fetch |=> busy_q ##1 !busy_q)
      else $error("table fetch not two cycles");
   fetch_address_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_fetch |=> table_addr_o == tab_addr($past(thi_q), $past(tlo_q)))
      else $error("table address wrong");
   fetch_store_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) busy_q |=> ram_q[pend_q] == $past(table_data_i))
      else $error("table word not stored");
   or_mem_acc_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_or_mem |=> acc_q == ($past(rnib) | $past(acc_q)))
      else $error("memory OR result wrong");
   or_imm_acc_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_or_imm |=> acc_q == ($past(wnib) | $past(imm)))
      else $error("immediate OR result wrong");
   or_mem_wb_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i) is_or_mem_wb |=> ram_q[$past(raddr)] == acc_q)
      else $error("memory write-back wrong");
   or_imm_wb_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_or_imm_wb |=> ram_q[$past(widx)] == acc_q)
      else $error("register write-back wrong");
   rot_left_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_rot |=> cf_q == $past(rnib[nco_pkg::MSB]) && acc_q[0] == $past(cf_q)
      && ram_q[$past(raddr)] == acc_q)
      else $error("rotate left wrong");
   ptr_low_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_tlo |=> tlo_q == $past(rnib) && thi_q == $past(thi_q))
      else $error("low pointer load wrong");
   ptr_high_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_thi |=> thi_q == $past(rnib) && tlo_q == $past(tlo_q))
      else $error("high pointer load wrong");
   zero_track_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_or_mem || is_or_imm || is_rot || is_or_mem_wb || is_or_imm_wb
      |=> zf_q == (acc_q == nco_pkg::NIB_RST))
      else $error("zero flag mismatch");
   flags_hold_a: assert property (@(posedge clk_sys_i)
      disable iff (!rstn_i)
      is_fetch || is_tlo || is_thi |=> $stable(zf_q) && $stable(cf_q))
      else $error("flags changed");
endmodule : nco_core

// ---- tb/nco_core_bench.sv ----
// Self-checking bench for the nibble core OR, rotate and fetch decoder.
// Assumes the core alone: table ROM data and RAM preload come from here.
`timescale 1ns/100ps
module nco_core_bench;
   logic        clk_sys_i     = 1'b0;
   logic        rstn_i        = 1'b0;
   logic [15:0] instr_i       = 16'h0000;
   logic        instr_valid_i = 1'b0;
   logic [3:0]  table_data_i  = 4'h0;
   logic        load_en_i     = 1'b0;
   logic [6:0]  load_addr_i   = 7'h00;
   logic [3:0]  load_data_i   = 4'h0;
   logic [6:0]  peek_addr_i   = 7'h00;
   logic        instr_ready_o;
   logic        zero_flag_o;
   logic        carry_flag_o;
   logic [7:0]  table_addr_o;
   logic [3:0]  accumulator_o;
   logic [3:0]  table_pointer_low_o;
   logic [3:0]  table_pointer_high_o;
   logic [3:0]  peek_data_o;
   logic [3:0]  mem [128];
   logic [3:0]  m_accu, m_lo, m_hi;
   logic        m_zero, m_carry;
   logic [31:0] rnd;
   int          err_total, checks, seed;

   nco_core DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .table_data_i(table_data_i),
      .load_en_i(load_en_i), .load_addr_i(load_addr_i),
      .load_data_i(load_data_i), .peek_addr_i(peek_addr_i),
      .instr_ready_o(instr_ready_o), .table_addr_o(table_addr_o),
      .accumulator_o(accumulator_o), .zero_flag_o(zero_flag_o),
      .carry_flag_o(carry_flag_o),
      .table_pointer_low_o(table_pointer_low_o),
      .table_pointer_high_o(table_pointer_high_o),
      .peek_data_o(peek_data_o));

   // 25 MHz core clock
   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task finish_test;
      if (err_total == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test

   // Preload one RAM nibble and mirror it in the bench copy
   task load(input logic [6:0] a, input logic [3:0] d);
      @(posedge clk_sys_i);
      load_en_i   <= 1'b1;
      load_addr_i <= a;
      load_data_i <= d;
      @(posedge clk_sys_i);
      load_en_i <= 1'b0;
      mem[a] = d;
   endtask : load

   // Peek has one cycle of latency, so the address is set an edge early
   task peek(input logic [6:0] a);
      @(posedge clk_sys_i);
      peek_addr_i <= a;
      @(posedge clk_sys_i);
      #1 check({4'h0, peek_data_o}, {4'h0, mem[a]});
   endtask : peek

   // Issue one word, update the bench copy, compare every visible result
   task run(input logic [15:0] w, input logic [3:0] td);
      logic [6:0] a;
      logic [3:0] wi;
      logic       upd;
      a   = w[6:0];
      wi  = w[3:0];
      upd = 1'b1;
      @(posedge clk_sys_i);
      instr_i       <= w;
      instr_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      table_data_i  <= td;
      if (w[15:7] == nco_pkg::OP_TABLE_FETCH) begin
         #1 check(table_addr_o, m_hi * 8'h10 + m_lo);
         check({7'h00, instr_ready_o}, 8'h00);
         @(posedge clk_sys_i);
         mem[a] = td;
         upd = 1'b0;
      end
      else if (w[15:7] == nco_pkg::OP_TAB_LOW) begin
         m_lo = mem[a];
         upd = 1'b0;
      end
      else if (w[15:7] == nco_pkg::OP_TAB_HIGH) begin
         m_hi = mem[a];
         upd = 1'b0;
      end
      else if (w[15:7] == nco_pkg::OP_OR_MEM) m_accu = mem[a] | m_accu;
      else if (w[15:7] == nco_pkg::OP_OR_MEM_WB) begin
         m_accu = mem[a] | m_accu;
         mem[a] = m_accu;
      end
      else if (w[15:7] == nco_pkg::OP_ROT_LEFT) begin
         m_accu  = {mem[a][2:0], m_carry};
         m_carry = mem[a][3];
         mem[a]  = m_accu;
      end
      else if (w[15:8] == nco_pkg::OP_OR_IMM) m_accu = mem[wi] | w[7:4];
      else if (w[15:8] == nco_pkg::OP_OR_IMM_WB) begin
         m_accu  = mem[wi] | w[7:4];
         mem[wi] = m_accu;
      end
      else upd = 1'b0;
      if (upd) m_zero = (m_accu == 4'h0);
      #1 check({4'h0, accumulator_o}, {4'h0, m_accu});
      check({7'h00, zero_flag_o}, {7'h00, m_zero});
      check({7'h00, carry_flag_o}, {7'h00, m_carry});
      check({table_pointer_high_o, table_pointer_low_o}, {m_hi, m_lo});
      check({7'h00, instr_ready_o}, 8'h01);
      peek(w[15:9] == 7'h0f ? {3'h0, wi} : a);
   endtask : run

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 74969;
      err_total = 0;
      checks = 0;
      {m_accu, m_lo, m_hi, m_zero, m_carry} = '0;
      repeat (7) @(posedge clk_sys_i);
      #1 check({instr_ready_o, accumulator_o, zero_flag_o}, 8'h00);
      @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      for (int i = 0; i < 128; i++) begin
         rnd = $random(seed);
         load(i[6:0], rnd[3:0]);
      end
      // Zero result, carry in and out, pointer boundary corners
      load(7'h05, 4'h0);
      run({nco_pkg::OP_OR_MEM, 7'h05}, 4'h0);
      load(7'h06, 4'h8);
      run({nco_pkg::OP_ROT_LEFT, 7'h06}, 4'h0);
      run({nco_pkg::OP_ROT_LEFT, 7'h06}, 4'h0);
      load(7'h10, 4'hf);
      run({nco_pkg::OP_TAB_LOW, 7'h10}, 4'h0);
      run({nco_pkg::OP_TAB_HIGH, 7'h10}, 4'h0);
      run({nco_pkg::OP_TABLE_FETCH, 7'h7f}, 4'ha);
      // A word held through the busy cycle must be taken once, after it
      load(7'h20, 4'hc);
      @(posedge clk_sys_i);
      instr_i       <= {nco_pkg::OP_TABLE_FETCH, 7'h20};
      instr_valid_i <= 1'b1;
      table_data_i  <= 4'h3;
      @(posedge clk_sys_i);
      instr_i <= {1'b0, nco_pkg::OP_OR_MEM[7:0], 7'h20};
      repeat (2) @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      mem[7'h20] = 4'h3;
      m_accu     = m_accu | 4'h3;
      m_zero     = (m_accu == 4'h0);
      #1 check({4'h0, accumulator_o}, {4'h0, m_accu});
      check({7'h00, zero_flag_o}, {7'h00, m_zero});
      peek(7'h20);
      // Random mix of every opcode plus an unused word
      repeat (300) begin
         rnd = $random(seed);
         case (rnd[31:28] % 4'h9)
            4'h0: run({nco_pkg::OP_TABLE_FETCH, rnd[6:0]}, rnd[11:8]);
            4'h1: run({nco_pkg::OP_TAB_LOW, rnd[6:0]}, rnd[11:8]);
            4'h2: run({nco_pkg::OP_TAB_HIGH, rnd[6:0]}, rnd[11:8]);
            4'h3: run({nco_pkg::OP_OR_MEM, rnd[6:0]}, rnd[11:8]);
            4'h4: run({nco_pkg::OP_OR_MEM_WB, rnd[6:0]}, rnd[11:8]);
            4'h5: run({nco_pkg::OP_ROT_LEFT, rnd[6:0]}, rnd[11:8]);
            4'h6: run({nco_pkg::OP_OR_IMM, rnd[7:0]}, rnd[11:8]);
            4'h7: run({nco_pkg::OP_OR_IMM_WB, rnd[7:0]}, rnd[11:8]);
            default: run(16'h0000, rnd[11:8]);
         endcase
      end
      finish_test();
   end

   // Watchdog well beyond the expected run of about fifteen hundred cycles
   initial begin
      #400000;
      err_total++;
      finish_test();
   end
endmodule : nco_core_bench
